// ### verilog/adc_host_end.sv
module adc_word_fifo #(
    parameter int WIDTH = 16,                    // Word width.
    parameter int DEPTH = 32                     // Words held.
) (
    input  wire logic             clk,           // Clock.
    input  wire logic             rst,           // Asynchronous reset, active high.
    input  wire logic             in_valid,      // Word offered.
    output logic                  in_ready,      // Room for a word.
    input  wire logic [WIDTH-1:0] in_data,       // Word written.
    output logic                  out_valid,     // Word available.
    input  wire logic             out_ready,     // Reader takes the word.
    output logic [WIDTH-1:0]      out_data       // Oldest word.
);
    localparam int PTR_W = $clog2(DEPTH);        // Pointer width.

    logic [WIDTH-1:0] mem_ff [DEPTH];            // Storage.
    logic [PTR_W-1:0] wr_ff;                     // Write index.
    logic [PTR_W-1:0] rd_ff;                     // Read index.
    logic [PTR_W:0]   count_ff;                  // Words held.
    logic             push;                      // Write this cycle.
    logic             pop;                       // Read this cycle.

    assign in_ready  = (count_ff != (PTR_W + 1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_ff[rd_ff];

    // Pointers wrap at the depth; the count tracks fill level.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ff    <= '0;
            rd_ff    <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == (PTR_W)'(DEPTH - 1)) ? '0 : wr_ff + (PTR_W)'(1);
            end
            if (pop) begin
                rd_ff <= (rd_ff == (PTR_W)'(DEPTH - 1)) ? '0 : rd_ff + (PTR_W)'(1);
            end
            count_ff <= count_ff + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
        end
    end

    // Storage is written without reset.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
endmodule

module adc_host_end (
    input  wire logic                 clk,          // Host clock.
    input  wire logic                 rst,          // Asynchronous reset, active high.
    adc_link_if.host                  link,         // Pins toward the device.
    input  wire logic                 run,          // High to convert continuously.
    input  wire logic                 chain_mode,   // High for daisy-chain wiring.
    output logic                      busy,         // High while a cycle is running.
    output logic                      word_valid,   // Result word available.
    input  wire logic                 word_ready,   // Reader takes the word.
    output logic [15:0]               word_data     // Oldest result word.
);

    adc_link_pkg::host_state_e state_ff;        // Cycle state.
    adc_link_pkg::cnt_t        phase_ff;        // Cycles in this phase.
    adc_link_pkg::cnt_t        cyc_ff;          // Cycles since last start.
    adc_link_pkg::bit_idx_t    bit_ff;          // Bit being read.
    adc_link_pkg::word_t       shreg_ff;        // Bits gathered.
    logic [1:0]                sdo_sync_ff;     // Data pin synchroniser.
    logic                      cnv_ff;          // Start pin level.
    logic                      sdi_ff;          // Select pin level.
    logic                      sck_ff;          // Serial clock level.
    logic                      push_ff;         // Word completed this cycle.
    logic                      fifo_ready;      // Room for another word.
    logic                      start;           // Begin a conversion now.
    logic                      half_end;        // Serial clock toggles now.
    logic                      read_end;        // Last falling edge now.

    // The select level settles for a cycle before any start edge.
    assign start    = (state_ff == adc_link_pkg::HOST_IDLE) & run & fifo_ready & (sdi_ff != chain_mode);  // R8
    assign half_end = (state_ff == adc_link_pkg::HOST_READ) && (phase_ff == adc_link_pkg::SCK_HALF_LAST);
    assign read_end = half_end & sck_ff & (bit_ff == adc_link_pkg::BIT_LAST);

    // Data pin passes two flip-flops before it is read.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdo_sync_ff <= 2'h0;
        end else begin
            sdo_sync_ff <= {sdo_sync_ff[0], link.serial_data_out};
        end
    end

    // Cycle sequence: start, wait out conversion, read, acquire.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= adc_link_pkg::HOST_IDLE;
            phase_ff <= '0;
        end else begin
            case (state_ff)
                adc_link_pkg::HOST_IDLE: begin
                    // A full buffer stalls the next conversion.
                    if (start) begin
                        state_ff <= adc_link_pkg::HOST_CONV;
                        phase_ff <= '0;
                    end
                end
                adc_link_pkg::HOST_CONV: begin
                    // Start stays high for the whole longest conversion.
                    if (phase_ff == adc_link_pkg::HOST_CONV_LAST) begin
                        state_ff <= adc_link_pkg::HOST_READ;  // R1
                        phase_ff <= '0;
                    end else begin
                        phase_ff <= phase_ff + adc_link_pkg::CNT_ONE;  // R2
                    end
                end
                adc_link_pkg::HOST_READ: begin
                    // Half periods of the serial clock.
                    if (read_end) begin
                        state_ff <= adc_link_pkg::HOST_ACQ;
                        phase_ff <= '0;
                    end else if (half_end) begin
                        phase_ff <= '0;  // R3 R4
                    end else begin
                        phase_ff <= phase_ff + adc_link_pkg::CNT_ONE;
                    end
                end
                adc_link_pkg::HOST_ACQ: begin
                    // Acquisition and cycle time must both elapse.
                    if (phase_ff >= adc_link_pkg::ACQ_LAST && cyc_ff >= adc_link_pkg::CYC_LAST) begin
                        state_ff <= adc_link_pkg::HOST_IDLE;  // R12
                    end else if (phase_ff != adc_link_pkg::ACQ_LAST) begin
                        phase_ff <= phase_ff + adc_link_pkg::CNT_ONE;
                    end
                end
                default: begin
                    state_ff <= adc_link_pkg::HOST_IDLE;
                end
            endcase
        end
    end

    // Time since the last start, held at its limit.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cyc_ff <= '0;
        end else if (start) begin
            cyc_ff <= '0;
        end else if (cyc_ff != adc_link_pkg::CYC_LAST) begin
            cyc_ff <= cyc_ff + adc_link_pkg::CNT_ONE;  // R12
        end
    end

    // Start pin rises on start and falls when reading begins.
    // Select sits high in select wiring and low in chain wiring.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnv_ff <= 1'h0;
            sdi_ff <= 1'h0;
        end else begin
            sdi_ff <= ~chain_mode;  // R8 R10
            if (start) begin
                cnv_ff <= 1'h1;
            end else if (state_ff == adc_link_pkg::HOST_CONV && phase_ff == adc_link_pkg::HOST_CONV_LAST) begin
                cnv_ff <= 1'h0;
            end
        end
    end

    // Serial clock idles low, so it is steady at the start edge.
    // Bits are taken on the rising edge, mid-way between device changes.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sck_ff   <= 1'h0;
            bit_ff   <= '0;
            shreg_ff <= '0;
        end else if (start) begin
            bit_ff <= '0;  // R9
        end else if (half_end) begin
            sck_ff <= ~sck_ff;
            if (!sck_ff) begin
                shreg_ff <= {shreg_ff[adc_link_pkg::DATA_W-2:0], sdo_sync_ff[1]};  // R5
            end else if (bit_ff != adc_link_pkg::BIT_LAST) begin
                bit_ff <= bit_ff + adc_link_pkg::bit_idx_t'(1);
            end
        end
    end

    // One push after the sixteenth bit; room was checked at start.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            push_ff <= 1'h0;
        end else begin
            push_ff <= read_end;
        end
    end

    adc_word_fifo #(
        .WIDTH (adc_link_pkg::DATA_W),
        .DEPTH (adc_link_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push_ff),
        .in_ready  (fifo_ready),
        .in_data   (shreg_ff),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .out_data  (word_data)
    );

    assign link.convert_start    = cnv_ff;
    assign link.serial_in_select = sdi_ff;
    assign link.sck              = sck_ff;
    assign busy                  = (state_ff != adc_link_pkg::HOST_IDLE);

endmodule

// ### verilog/adc_link_pkg.sv
package adc_link_pkg;
    // Widths of the result word and of the link counters.
    localparam int DATA_W      = 16;              // Result word width.
    localparam int IDX_W       = $clog2(DATA_W);  // Bit index width.
    localparam int CNT_W       = 8;               // Local timing counter width.
    localparam int LINK_CNT_W  = 6;               // Link bit counter width.
    localparam int SYNC_STAGES = 2;               // Flip-flops in each synchroniser.
    localparam int FIFO_DEPTH  = 32;              // Words buffered at the host.

    // Times as printed, in their own units.
    localparam int CLK_NS           = 100;        // Local clock period.
    localparam int CONV_MIN_NS      = 500;        // Shortest conversion.
    localparam int CONV_MAX_NS      = 2200;       // Longest conversion.
    localparam int CNVH_MIN_NS      = 10;         // Least start pulse width.
    localparam int ACQ_MIN_NS       = 1800;       // Least acquisition time.
    localparam int CYC_MIN_NS       = 4000;       // Least time between starts.
    localparam int SCK_CS_MIN_NS    = 15;         // Least clock period, select mode.
    localparam int SCK_CHAIN_MIN_NS = 17;         // Least clock period, chain mode.

    // Cycle counts derived from the times above.
    localparam int CONV_MIN_CYC  = (CONV_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_MAX_CYC  = (CONV_MAX_NS / CLK_NS < 1) ? 1 : CONV_MAX_NS / CLK_NS;
    localparam int CONV_DEV_CYC  = CONV_MAX_CYC - SYNC_STAGES - 1;
    localparam int CNVH_CYC      = (CNVH_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOST_CONV_CYC = (CONV_MAX_CYC + 1 > CNVH_CYC) ? CONV_MAX_CYC + 1 : CNVH_CYC;
    localparam int ACQ_CYC       = (ACQ_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_CYC       = (CYC_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCK_HALF_CYC  = SYNC_STAGES + 2;

    // Types shared by both ends.
    typedef logic [CNT_W-1:0]      cnt_t;
    typedef logic [LINK_CNT_W-1:0] link_cnt_t;
    typedef logic [IDX_W-1:0]      bit_idx_t;
    typedef logic [DATA_W-1:0]     word_t;

    // Sized compare values.
    localparam cnt_t      CNT_ONE       = cnt_t'(1);
    localparam cnt_t      CONV_DEV_LAST = cnt_t'(CONV_DEV_CYC - 1);
    localparam cnt_t      HOST_CONV_LAST = cnt_t'(HOST_CONV_CYC - 1);
    localparam cnt_t      ACQ_LAST      = cnt_t'(ACQ_CYC - 1);
    localparam cnt_t      CYC_LAST      = cnt_t'(CYC_CYC - 1);
    localparam cnt_t      SCK_HALF_LAST = cnt_t'(SCK_HALF_CYC - 1);
    localparam link_cnt_t WORD_LEN      = link_cnt_t'(DATA_W);
    localparam link_cnt_t LINK_ONE      = link_cnt_t'(1);
    localparam link_cnt_t LINK_CNT_MAX  = {LINK_CNT_W{1'b1}};
    localparam bit_idx_t  BIT_LAST      = bit_idx_t'(DATA_W - 1);

    // State encodings, Gray along the usual path.
    typedef enum logic {
        DEV_IDLE = 1'h0,
        DEV_CONV = 1'h1
    } dev_state_e;

    typedef enum logic [1:0] {
        HOST_IDLE = 2'h0,
        HOST_CONV = 2'h1,
        HOST_READ = 2'h3,
        HOST_ACQ  = 2'h2
    } host_state_e;
endpackage

// ### verilog/adc_link_if.sv
interface adc_link_if;
    logic convert_start;     // Start pulse from the host.
    logic serial_in_select;  // Select or chain input of the device.
    logic sck;               // Serial clock made by the host.
    logic sdo_out;           // Level the device drives on the data pin.
    logic sdo_oe_n;          // Low while the device drives the data pin.
    wire  serial_data_out;               // Resolved data pin.

    // A released data pin shows the inverse of the device's level, so a
    // host that samples it outside the frame reads a wrong bit.
    assign serial_data_out = sdo_oe_n ? ~sdo_out : sdo_out;

    modport dev (
        input  convert_start,
        input  serial_in_select,
        input  sck,
        output sdo_out,
        output sdo_oe_n
    );

    modport host (
        output convert_start,
        output serial_in_select,
        output sck,
        input  serial_data_out
    );
endinterface

// ### verilog/adc_dev_end.sv
// Function
// R1 - Conversion finishes 0.5 to 2.2 us after start.
// R2 - Host holds start high at least 10 ns.
// R3 - Select mode clock period at least 15 ns.
// R4 - Chain mode clock period at least 17 ns.
// R5 - Data changes only after falling clock edge.
// R6 - Select low puts result MSB on data.
// R7 - Data floats on select high or last edge.
// R8 - Select level caught at start rising edge.
// R9 - Clock level caught at start rising edge.
// R10 - Chain input shifted in on falling clock edge.
// R11 - Busy chain: data goes high after input high.
// R12 - Host spaces starts by full cycle time.
// R13 - Result is 16-bit binary, MSB first, no latency.
module adc_dev_end (
    input  wire logic                 clk,           // Internal conversion clock.
    input  wire logic                 rst,           // Asynchronous reset, active high.
    adc_link_if.dev                   link,          // Pins toward the host.
    input  wire logic [15:0]          sample_value,  // Digital stand-in for the input.
    input  wire logic                 chain_mode,    // High selects daisy-chain wiring.
    output logic                      converting,    // High while converting.
    output logic                      result_valid,  // High from a conversion's end until the next start.
    output logic [15:0]               result_word    // Last completed result.
);

    // Synchronisers for the pins read in the conversion domain.
    logic [1:0]               cnv_sync_ff;    // Start pin synchroniser.
    logic [1:0]               sdi_sync_ff;    // Select pin synchroniser.
    logic [1:0]               sck_sync_ff;    // Clock level synchroniser.
    logic                     cnv_prev_ff;    // Last synchronised start level.
    logic                     cnv_rise;       // Start rising edge seen.

    // Conversion state.
    adc_link_pkg::dev_state_e state_ff;       // Conversion state.
    adc_link_pkg::cnt_t       conv_cnt_ff;    // Cycles spent converting.
    logic                     conv_end;       // Last conversion cycle.
    logic                     four_wire_ff;   // Select pin acts as frame select.
    logic                     busy_en_ff;     // Busy indication enabled.
    adc_link_pkg::word_t      sample_ff;      // Input taken at the start edge.
    adc_link_pkg::word_t      result_ff;      // Completed result.
    logic                     done_ff;        // Result ready for readout.

    // Link domain.
    logic                     frame_idle;     // High outside a readout frame.
    logic                     frame_clr;      // Clears the link counters.
    adc_link_pkg::link_cnt_t  link_idx_ff;    // Falling edges seen in frame.
    adc_link_pkg::word_t      chain_ff;       // Bits shifted in from upstream.
    logic                     lead;           // Busy slot ahead of the MSB.
    adc_link_pkg::link_cnt_t  bit_pos;        // Result bit now on the pin.
    logic                     sdo_bit;        // Level for the data pin.

    // Two flip-flops on each pin before the conversion-domain logic reads it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnv_sync_ff <= 2'h0;
            sdi_sync_ff <= 2'h0;
            sck_sync_ff <= 2'h0;
        end else begin
            cnv_sync_ff <= {cnv_sync_ff[0], link.convert_start};
            sdi_sync_ff <= {sdi_sync_ff[0], link.serial_in_select};
            sck_sync_ff <= {sck_sync_ff[0], link.sck};
        end
    end

    // The edge detector reads only the second synchroniser stage.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnv_prev_ff <= 1'h0;
        end else begin
            cnv_prev_ff <= cnv_sync_ff[1];
        end
    end

    assign cnv_rise = cnv_sync_ff[1] & ~cnv_prev_ff;
    assign conv_end = (state_ff == adc_link_pkg::DEV_CONV) && (conv_cnt_ff == adc_link_pkg::CONV_DEV_LAST);

    // Conversion runs a fixed count that fits inside the allowed window.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff    <= adc_link_pkg::DEV_IDLE;
            conv_cnt_ff <= '0;
        end else begin
            case (state_ff)
                adc_link_pkg::DEV_IDLE: begin
                    // A start edge begins a conversion.
                    if (cnv_rise) begin
                        state_ff    <= adc_link_pkg::DEV_CONV;  // R1
                        conv_cnt_ff <= '0;
                    end
                end
                adc_link_pkg::DEV_CONV: begin
                    // Further start edges are ignored until the end.
                    if (conv_end) begin
                        state_ff <= adc_link_pkg::DEV_IDLE;  // R1
                    end else begin
                        conv_cnt_ff <= conv_cnt_ff + adc_link_pkg::CNT_ONE;
                    end
                end
                default: begin
                    state_ff <= adc_link_pkg::DEV_IDLE;
                end
            endcase
        end
    end

    // Wiring options are caught at the start edge and held until the next.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            four_wire_ff <= 1'h0;
            busy_en_ff   <= 1'h0;
        end else if (cnv_rise && state_ff == adc_link_pkg::DEV_IDLE) begin
            // Select high at the start edge lets the start pin frame the readout.
            four_wire_ff <= ~sdi_sync_ff[1];  // R8
            busy_en_ff   <= sck_sync_ff[1];  // R9
        end
    end

    // The input is taken at the start edge and becomes the result when the conversion ends.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample_ff <= '0;
        end else if (cnv_rise && state_ff == adc_link_pkg::DEV_IDLE) begin
            sample_ff <= sample_value;
        end
    end

    // The result updates in the cycle its conversion ends.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_ff <= '0;
        end else if (conv_end) begin
            result_ff <= sample_ff;  // R13
        end
    end

    // The ready flag drops at each start and rises at each end.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_ff <= 1'h0;
        end else if (conv_end) begin
            done_ff <= 1'h1;  // R1
        end else if (cnv_rise && state_ff == adc_link_pkg::DEV_IDLE) begin
            done_ff <= 1'h0;
        end
    end

    // The frame is selected by the start pin, or by the select pin in
    // four-wire wiring. Mode bits change only at a start edge, so they
    // are steady during any frame.
    assign frame_idle = (~chain_mode & four_wire_ff) ? link.serial_in_select : link.convert_start;
    assign frame_clr  = rst | frame_idle;

    // Link logic runs on the falling serial clock and is cleared by the
    // frame's own select, since the clock stands still between frames.
    always_ff @(negedge link.sck or posedge frame_clr) begin
        if (frame_clr) begin
            link_idx_ff <= '0;
        end else if (link_idx_ff != adc_link_pkg::LINK_CNT_MAX) begin
            link_idx_ff <= link_idx_ff + adc_link_pkg::LINK_ONE;  // R5
        end
    end

    // Upstream bits enter on each falling edge in chain wiring.
    always_ff @(negedge link.sck or posedge frame_clr) begin
        if (frame_clr) begin
            chain_ff <= '0;
        end else begin
            chain_ff <= {chain_ff[adc_link_pkg::DATA_W-2:0], link.serial_in_select};  // R10
        end
    end

    assign lead = chain_mode & busy_en_ff;

    // Choose the pin level: busy slot, own result MSB first, then chain.
    // The result register is only read after the host has waited the
    // conversion time, so it is steady while the link reads it.
    always_comb begin
        bit_pos = link_idx_ff - adc_link_pkg::link_cnt_t'(lead);
        sdo_bit = 1'h0;
        if (lead && link_idx_ff == '0) begin
            // Busy slot: high once done and the upstream input is high.
            sdo_bit = done_ff & link.serial_in_select;  // R11
        end else if (bit_pos < adc_link_pkg::WORD_LEN) begin
            // Own result, most significant bit first.
            sdo_bit = result_ff[adc_link_pkg::BIT_LAST - adc_link_pkg::bit_idx_t'(bit_pos)];  // R6
        end else begin
            // Pass upstream bits on after the own word.
            sdo_bit = chain_ff[adc_link_pkg::DATA_W-1];  // R10
        end
    end

    assign link.sdo_out = sdo_bit;  // R5

    // Select wiring drives only inside a frame and before the last edge.
    // Chain wiring drives its output whenever reset is low.
    assign link.sdo_oe_n = rst | (~chain_mode & (frame_idle | (bit_pos >= adc_link_pkg::WORD_LEN)));  // R7

    // User-side status.
    assign converting   = (state_ff == adc_link_pkg::DEV_CONV);
    assign result_valid = done_ff;
    assign result_word  = result_ff;

endmodule

// ### bench/adc_link_checker.sv
module adc_link_checker (
    input  wire logic clk,              // Host clock.
    input  wire logic rst,              // Reset.
    input  wire logic convert_start,    // Start pin.
    input  wire logic serial_in_select, // Select pin.
    input  wire logic sck,              // Serial clock.
    input  wire logic sdo_out,          // Data level.
    input  wire logic sdo_oe_n          // Data drive, low active.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] gap_ff;   // Cycles since the last start.
    logic [4:0] nfall_ff; // Clock falls in this readout.
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Counts cycles from each start, saturating.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) gap_ff <= 6'h3f;
        else if ($rose(convert_start)) gap_ff <= 6'h00;
        else if (gap_ff != 6'h3f) gap_ff <= gap_ff + 6'h01;
    end
    // Counts clock falls since the frame opened.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nfall_ff <= 5'h00;
        end else if (convert_start) begin
            nfall_ff <= 5'h00;
        end else if ($fell(sck)) begin
            nfall_ff <= nfall_ff + 5'h01;
        end
    end
    AST_GAP: assert property ($rose(convert_start) |-> gap_ff >= 6'h27) else $error("starts too close");
    AST_HOLD: assert property ($fell(convert_start) |-> $past(convert_start, 22)) else $error("read early");
    AST_SCK: assert property ($changed(sck) |=> $stable(sck) [*3]) else $error("clock too fast");
    AST_SEL: assert property ($rose(convert_start) |-> serial_in_select && $past(serial_in_select))
        else $error("select not set up");
    AST_OFF: assert property (convert_start && $past(convert_start) |-> sdo_oe_n) else $error("driven");
    AST_LAST: assert property (nfall_ff == 5'h10 |-> sdo_oe_n) else $error("not released");
    AST_MSB: assert property ($fell(convert_start) |-> !sdo_oe_n) else $error("not driven");
    AST_EDGE: assert property (!sdo_oe_n && !$past(sdo_oe_n) && $changed(sdo_out) |-> $fell(sck))
        else $error("data moved off edge");
    cover property ($rose(convert_start));
    cover property (nfall_ff == 5'h10);
    cover property ($fell(convert_start));
endmodule

// ### bench/adc_conversion_serial_readout_tb.sv
module adc_conversion_serial_readout_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;        // Host clock, 100 ns.
    logic        lclk = 1'b0;       // Device clock, 64 ns.
    logic        rst = 1'b1;        // Reset.
    logic        run = 1'b0;        // Keeps the host converting.
    logic        word_ready = 1'b0; // Pops a word.
    logic        conv_d = 1'b0;     // Delayed busy flag of the device.
    logic [15:0] sample_value;      // Value the device converts.
    logic        converting, result_valid, busy, word_valid;
    logic [15:0] result_word, word_data;
    int          miscompares = 0;   // Mismatches.
    int          n_checks = 0;      // Comparisons.
    int          k = 0;             // Conversions finished.
    adc_link_if link ();
    adc_dev_end adc_dev_end_i (.clk(lclk), .rst(rst), .link(link), .sample_value(sample_value), .chain_mode(1'b0),
        .converting(converting), .result_valid(result_valid), .result_word(result_word));
    adc_host_end adc_host_end_i (.clk(clk), .rst(rst), .link(link), .run(run), .chain_mode(1'b0), .busy(busy),
        .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
    adc_link_checker adc_link_checker_i (.clk(clk), .rst(rst), .convert_start(link.convert_start),
        .serial_in_select(link.serial_in_select), .sck(link.sck), .sdo_out(link.sdo_out), .sdo_oe_n(link.sdo_oe_n));
    always #50 clk = ~clk;
    always #32 lclk = ~lclk;
    // Sample for conversion i.
    function automatic logic [15:0] tbl(int i);
        return 16'(i * 32'h4e6d) ^ 16'ha5a5;
    endfunction
    // Moves to the next sample once a conversion ends.
    always @(posedge lclk) begin
        conv_d <= converting;
        if (conv_d && !converting) begin
            k <= k + 1;
            sample_value <= tbl(k + 1);
        end
    end
    task automatic check(logic [16:0] got, logic [16:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        #800000;
        miscompares++;
        close_out();
    end
    // Fills the buffer until the host stops, then drains it in order.
    initial begin
        sample_value = tbl(0);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        run <= 1'b1;
        for (int i = 0; i < 6000 && k < 32; i++) @(posedge clk);
        repeat (200) @(posedge clk);
        #1 check(17'(k), 17'h00020);
        check({result_valid, result_word}, {1'b1, tbl(31)});
        check({15'h0000, busy, converting}, 17'h00000);
        @(posedge clk) run <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            #1 check({word_valid, word_data}, {1'b1, tbl(i)});
            @(posedge clk) word_ready <= 1'b1;
            @(posedge clk) word_ready <= 1'b0;
        end
        #1 check({word_valid, 16'h0000}, 17'h00000);
        close_out();
    end
endmodule
